// ### src/dnp_pkg.sv
package dnp_pkg;

  // configuration space placement: command in bytes 1:0, status in 3:2 of one dword
  localparam logic [9:0] DNP_CMD_STS_DWORD = 10'h001;
  localparam logic [11:0] DNP_CMD_OFFSET = 12'h004;
  localparam logic [11:0] DNP_STS_OFFSET = 12'h006;
  localparam int DNP_CFG_AW = 10;
  localparam int DNP_CFG_DW = 32;
  localparam int DNP_CFG_BEW = 4;
  localparam int DNP_REG_W = 16;

  // command field positions
  localparam int DNP_CMD_IO_RESPONSE_ALLOW = 0;
  localparam int DNP_CMD_MEM_RESPONSE_ALLOW = 1;
  localparam int DNP_CMD_INITIATOR_ALLOW = 2;
  localparam int DNP_CMD_SPECIAL_CYCLE = 3;
  localparam int DNP_CMD_WRITE_INVALIDATE_ALLOW = 4;
  localparam int DNP_CMD_PALETTE_SNOOP_ALLOW = 5;
  localparam int DNP_CMD_PARITY_RESPONSE_ALLOW = 6;
  localparam int DNP_CMD_STEPPING_ALLOW = 7;
  localparam int DNP_CMD_SYSTEM_ERROR_FORWARD_ALLOW = 8;
  localparam int DNP_CMD_BACK_TO_BACK_ALLOW = 9;
  localparam int DNP_CMD_INT_DISABLE = 10;

  // only bits 10, 8, 6, 2, 1, 0 are storage
  localparam logic [15:0] DNP_CMD_WRITE_MASK = 16'h0547;
  localparam logic [15:0] DNP_CMD_RESET = 16'h0000;

  // status field positions
  localparam int DNP_STS_INT_STATUS = 3;
  localparam int DNP_STS_CAP_LIST = 4;
  localparam int DNP_STS_MASTER_ABORT_RECEIVED = 13;
  localparam int DNP_STS_SYSTEM_ERROR_SENT = 14;
  localparam int DNP_STS_POISONED_TLP_SEEN = 15;
  localparam int DNP_STS_FLAG_N = 2;
  localparam logic [15:0] DNP_STS_RESET = 16'h0010;
  localparam logic [1:0] DNP_STS_FLAG_RESET = 2'h0;

  // error message classes coming up from the secondary side
  typedef enum logic [1:0] {
    DNP_ERR_COR = 2'b00,
    DNP_ERR_NONFATAL = 2'b01,
    DNP_ERR_FATAL = 2'b10,
    DNP_ERR_NONE = 2'b11
  } dnp_err_t;

  // address space of a request arriving on the downstream link
  typedef enum logic [1:0] {
    DNP_SPACE_MEM = 2'b00,
    DNP_SPACE_IO = 2'b01,
    DNP_SPACE_OTHER = 2'b10,
    DNP_SPACE_RSVD = 2'b11
  } dnp_space_t;

endpackage

// ### src/dnp_rw_field.sv
`timescale 1ns/1ps
`default_nettype none
// byte-lane write register; a write stores a one only in bits of the write mask
module dnp_rw_field #(
  parameter int W = 16,
  parameter logic [W-1:0] RESET_VALUE = '0,
  parameter logic [W-1:0] WRITE_MASK = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // write request
  input wire logic wr_en,
  input wire logic [W/8-1:0] wr_be,
  input wire logic [W-1:0] wr_data,
  // stored value
  output logic [W-1:0] q
);

  logic [W-1:0] field_q;
  logic [W-1:0] field_d;

  // per-lane merge; lanes without an enable keep their old contents
  genvar g;
  generate
    for (g = 0; g < W / 8; g = g + 1) begin : g_lane
      assign field_d[g*8 +: 8] = (wr_en && wr_be[g]) ?
        (wr_data[g*8 +: 8] & WRITE_MASK[g*8 +: 8]) : field_q[g*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      field_q <= RESET_VALUE;
    end else begin
      field_q <= field_d;
    end
  end

  assign q = field_q;

endmodule // dnp_rw_field
`default_nettype wire

// ### src/dnp_w1c_flags.sv
`timescale 1ns/1ps
`default_nettype none
// sticky event flags, cleared by writing one; a set in the clear cycle survives
module dnp_w1c_flags #(
  parameter int N = 2,
  parameter logic [N-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // hardware events and software clears
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  // flag state
  output logic [N-1:0] q
);

  logic [N-1:0] flag_q;
  logic [N-1:0] flag_d;

  // set is or-ed in last so it wins over a same-cycle clear
  assign flag_d = (flag_q & ~clr) | set;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q <= RESET_VALUE;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign q = flag_q;

endmodule // dnp_w1c_flags
`default_nettype wire

// ### src/dnp_port_cmd_status.sv
`timescale 1ns/1ps
`default_nettype none
module dnp_port_cmd_status (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration access from the primary side
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [dnp_pkg::DNP_CFG_AW-1:0] cfg_addr,
  input wire logic [dnp_pkg::DNP_CFG_BEW-1:0] cfg_be,
  input wire logic [dnp_pkg::DNP_CFG_DW-1:0] cfg_wdata,
  output logic [dnp_pkg::DNP_CFG_DW-1:0] cfg_rdata,
  output logic cfg_rd_ack,
  // own hot-plug interrupt
  input wire logic hp_int_req,
  output logic intx_pri_assert,
  // INTx messages from the downstream link
  input wire logic dn_intx_msg_valid,
  input wire logic [2:0] dn_intx_msg_code,
  output logic up_intx_msg_valid,
  output logic [2:0] up_intx_msg_code,
  // error messages forwarded from the secondary side
  input wire logic sec_err_valid,
  input wire dnp_pkg::dnp_err_t sec_err_type,
  output logic pri_err_valid,
  output dnp_pkg::dnp_err_t pri_err_type,
  // poisoned TLP seen on the internal virtual bus
  input wire logic pri_poison_rx,
  // requests arriving on the downstream link
  input wire logic dn_req_valid,
  input wire dnp_pkg::dnp_space_t dn_req_space,
  output logic dn_req_done,
  output logic dn_req_accept,
  // static enables toward the datapath
  output logic dn_initiate_allow,
  output logic dn_mem_forward_allow,
  output logic dn_io_forward_allow
);
  import dnp_pkg::*;

  // lane mask from byte enables, used for the status half of the dword
  function automatic logic [15:0] dnp_lane_mask(input logic [1:0] be);
    dnp_lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // address decode
  // one dword holds both registers, lanes pick the halves
  logic cfg_hit;
  logic cmd_wr;
  logic [1:0] cmd_be;
  logic [1:0] sts_be;
  logic [15:0] sts_wmask;
  logic [15:0] sts_wdata;

  // command and status share one dword; anything else reads as zero
  assign cfg_hit = (cfg_addr == DNP_CMD_STS_DWORD);
  assign cmd_wr = cfg_wr_en && cfg_hit;
  assign cmd_be = cfg_be[1:0];
  assign sts_be = cfg_be[3:2];
  assign sts_wmask = cmd_wr ? dnp_lane_mask(sts_be) : 16'h0000;
  assign sts_wdata = cfg_wdata[31:16];

  // command register
  // six stored bits, the rest are wired or reserved
  logic [15:0] cmd_q;

  // read-only and reserved bits are masked away before storage
  dnp_rw_field #(
    .W(DNP_REG_W),
    .RESET_VALUE(DNP_CMD_RESET),
    .WRITE_MASK(DNP_CMD_WRITE_MASK)
  ) u_cmd (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(cmd_wr),
    .wr_be(cmd_be),
    .wr_data(cfg_wdata[15:0]),
    .q(cmd_q)
  );

  // named views of the stored command bits
  logic io_response_allow;
  logic mem_response_allow;
  logic initiator_allow;
  logic parity_response_allow;
  logic system_error_forward_allow;
  logic int_disable;

  // bit picks by package position
  assign io_response_allow = cmd_q[DNP_CMD_IO_RESPONSE_ALLOW];
  assign mem_response_allow = cmd_q[DNP_CMD_MEM_RESPONSE_ALLOW];
  assign initiator_allow = cmd_q[DNP_CMD_INITIATOR_ALLOW];
  // stored and readable, nothing else looks at it
  assign parity_response_allow = cmd_q[DNP_CMD_PARITY_RESPONSE_ALLOW];
  assign system_error_forward_allow = cmd_q[DNP_CMD_SYSTEM_ERROR_FORWARD_ALLOW];
  assign int_disable = cmd_q[DNP_CMD_INT_DISABLE];

  // read image of the command word; hardwired bits are named zeros
  logic back_to_back_allow;
  logic stepping_allow;
  logic palette_snoop_allow;
  logic write_invalidate_allow;
  logic special_cycle_allow;
  logic [15:0] cmd_rd;

  // wired to zero, never stored whatever software writes
  assign back_to_back_allow = 1'b0;
  assign stepping_allow = 1'b0;
  assign palette_snoop_allow = 1'b0;
  assign write_invalidate_allow = 1'b0;
  assign special_cycle_allow = 1'b0;

  // every bit placed by its package position; 15:11 stay reserved zero
  always_comb begin
    cmd_rd = 16'h0000;
    cmd_rd[DNP_CMD_IO_RESPONSE_ALLOW] = io_response_allow;
    cmd_rd[DNP_CMD_MEM_RESPONSE_ALLOW] = mem_response_allow;
    cmd_rd[DNP_CMD_INITIATOR_ALLOW] = initiator_allow;
    cmd_rd[DNP_CMD_SPECIAL_CYCLE] = special_cycle_allow;
    cmd_rd[DNP_CMD_WRITE_INVALIDATE_ALLOW] = write_invalidate_allow;
    cmd_rd[DNP_CMD_PALETTE_SNOOP_ALLOW] = palette_snoop_allow;
    cmd_rd[DNP_CMD_PARITY_RESPONSE_ALLOW] = parity_response_allow;
    cmd_rd[DNP_CMD_STEPPING_ALLOW] = stepping_allow;
    cmd_rd[DNP_CMD_SYSTEM_ERROR_FORWARD_ALLOW] = system_error_forward_allow;
    cmd_rd[DNP_CMD_BACK_TO_BACK_ALLOW] = back_to_back_allow;
    cmd_rd[DNP_CMD_INT_DISABLE] = int_disable;
  end

  // error message forwarding to the primary side
  // one register stage, so messages keep their order
  logic err_is_cor;
  logic err_is_severe;
  logic err_fwd;
  logic severe_sent;

  // message class decode; the unused code falls in neither class
  assign err_is_cor = (sec_err_type == DNP_ERR_COR);
  assign err_is_severe = (sec_err_type == DNP_ERR_NONFATAL) ||
                         (sec_err_type == DNP_ERR_FATAL);
  // correctable ones never look at the enable
  assign err_fwd = sec_err_valid &&
                   (err_is_cor ||
                    (err_is_severe && system_error_forward_allow));
  assign severe_sent = sec_err_valid && err_is_severe &&
                       system_error_forward_allow;

  // registered message toward the primary side
  logic pri_err_valid_q;
  dnp_err_t pri_err_type_q;

  // one-cycle message strobe, type held until the next message
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pri_err_valid_q <= 1'b0;
      pri_err_type_q <= DNP_ERR_NONE;
    end else begin
      pri_err_valid_q <= err_fwd;
      if (err_fwd) begin
        pri_err_type_q <= sec_err_type;
      end
    end
  end

  // status flags
  // two sticky flags; everything else is wired except the registered interrupt pending bit
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [1:0] flag_q;

  // poison sets the flag whatever the parity response bit holds
  assign flag_set = {pri_poison_rx, severe_sent};
  // only a one in an enabled lane clears; zeros leave the flag
  assign flag_clr = {sts_wdata[DNP_STS_POISONED_TLP_SEEN] &
                     sts_wmask[DNP_STS_POISONED_TLP_SEEN],
                     sts_wdata[DNP_STS_SYSTEM_ERROR_SENT] &
                     sts_wmask[DNP_STS_SYSTEM_ERROR_SENT]};

  dnp_w1c_flags #(
    .N(DNP_STS_FLAG_N),
    .RESET_VALUE(DNP_STS_FLAG_RESET)
  ) u_flags (
    .clk(clk),
    .arst_n(arst_n),
    .set(flag_set),
    .clr(flag_clr),
    .q(flag_q)
  );

  // named views of the flag bits; abort is never raised
  logic poisoned_tlp_seen;
  logic system_error_sent;
  logic master_abort_received;

  assign poisoned_tlp_seen = flag_q[1];
  assign system_error_sent = flag_q[0];
  assign master_abort_received = 1'b0;

  // own interrupt: pending state and gated assertion
  // disable bit gates the message, never the pending state
  logic int_pending_q;
  logic intx_assert_q;
  logic intx_assert_d;

  // pending shows in status even while the message is blocked
  assign intx_assert_d = hp_int_req && !int_disable;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_pending_q <= 1'b0;
      intx_assert_q <= 1'b0;
    end else begin
      int_pending_q <= hp_int_req;
      intx_assert_q <= intx_assert_d;
    end
  end

  // read image of the status word; writes never touch read-only bits
  logic cap_list;
  logic [15:0] sts_rd;

  // capability bit always reads its reset value
  assign cap_list = DNP_STS_RESET[DNP_STS_CAP_LIST];
  // descending from bit 15; bits 12:5 and 2:0 read zero
  assign sts_rd = {poisoned_tlp_seen,
                   system_error_sent,
                   master_abort_received,
                   8'h00,
                   cap_list,
                   int_pending_q,
                   3'h0};

  // downstream INTx message pass-through
  // messages of other functions, so the disable bit is ignored
  // one-deep copy of the message
  logic up_intx_valid_q;
  logic [2:0] up_intx_code_q;

  // one register stage, no dependence on the disable bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_intx_valid_q <= 1'b0;
      up_intx_code_q <= 3'h0;
    end else begin
      up_intx_valid_q <= dn_intx_msg_valid;
      if (dn_intx_msg_valid) begin
        up_intx_code_q <= dn_intx_msg_code;
      end
    end
  end

  // downstream request gating
  // verdicts and enables share one clock of latency
  // per-space verdicts before registering
  logic mem_ok;
  logic io_ok;
  logic req_ok;

  // the initiator bit masks both spaces, then each has its own enable
  assign mem_ok = initiator_allow && mem_response_allow;
  assign io_ok = initiator_allow && io_response_allow;
  assign req_ok = (dn_req_space == DNP_SPACE_MEM) ? mem_ok :
                  (dn_req_space == DNP_SPACE_IO) ? io_ok :
                  (dn_req_space == DNP_SPACE_OTHER);

  // registered verdict and enables
  logic req_done_q;
  logic req_accept_q;
  logic init_allow_q;
  logic mem_fwd_q;
  logic io_fwd_q;

  // verdict one cycle after the request; enables lag the command by one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_done_q <= 1'b0;
      req_accept_q <= 1'b0;
      init_allow_q <= 1'b0;
      mem_fwd_q <= 1'b0;
      io_fwd_q <= 1'b0;
    end else begin
      req_done_q <= dn_req_valid;
      req_accept_q <= dn_req_valid && req_ok;
      init_allow_q <= initiator_allow;
      mem_fwd_q <= mem_ok;
      io_fwd_q <= io_ok;
    end
  end

  // read path
  // read and write in one cycle: the read sees the old value
  // registered read answer
  logic [31:0] rd_word;
  logic [31:0] rdata_q;
  logic rd_ack_q;

  // unmapped dwords answer with zero rather than holding old data
  assign rd_word = cfg_hit ? {sts_rd, cmd_rd} : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0000_0000;
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= cfg_rd_en;
      if (cfg_rd_en) begin
        rdata_q <= rd_word;
      end
    end
  end

  // outputs, all straight from flip-flops
  // plain renames, no logic past the registers
  assign cfg_rdata = rdata_q;
  assign cfg_rd_ack = rd_ack_q;
  assign intx_pri_assert = intx_assert_q;
  assign up_intx_msg_valid = up_intx_valid_q;
  assign up_intx_msg_code = up_intx_code_q;
  assign pri_err_valid = pri_err_valid_q;
  assign pri_err_type = pri_err_type_q;
  assign dn_req_done = req_done_q;
  assign dn_req_accept = req_accept_q;
  assign dn_initiate_allow = init_allow_q;
  assign dn_mem_forward_allow = mem_fwd_q;
  assign dn_io_forward_allow = io_fwd_q;

endmodule // dnp_port_cmd_status
`default_nettype wire

// ### verif/dnp_port_cmd_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port-level watcher for the command/status block
module dnp_port_cmd_status_checker (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration reads
  input wire logic cfg_rd_en,
  input wire logic [dnp_pkg::DNP_CFG_AW-1:0] cfg_addr,
  input wire logic [dnp_pkg::DNP_CFG_DW-1:0] cfg_rdata,
  input wire logic cfg_rd_ack,
  // interrupts
  input wire logic hp_int_req,
  input wire logic intx_pri_assert,
  input wire logic dn_intx_msg_valid,
  input wire logic [2:0] dn_intx_msg_code,
  input wire logic up_intx_msg_valid,
  input wire logic [2:0] up_intx_msg_code,
  // error messages
  input wire logic sec_err_valid,
  input wire dnp_pkg::dnp_err_t sec_err_type,
  input wire logic pri_err_valid,
  input wire dnp_pkg::dnp_err_t pri_err_type,
  // downstream requests and enables
  input wire logic dn_req_valid,
  input wire dnp_pkg::dnp_space_t dn_req_space,
  input wire logic dn_req_done,
  input wire logic dn_req_accept,
  input wire logic dn_initiate_allow,
  input wire logic dn_mem_forward_allow,
  input wire logic dn_io_forward_allow
);
  import dnp_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // fixed bits read the same whatever software wrote
  a_fixed_bits: assert property (
    cfg_rd_en && cfg_addr == DNP_CMD_STS_DWORD |=> cfg_rd_ack
      && (cfg_rdata & 32'h3FF7_FAB8) == 32'h0010_0000) else $error("fixed bits wrong");
  a_other_dword: assert property (
    cfg_rd_en && cfg_addr != DNP_CMD_STS_DWORD |=> cfg_rd_ack && cfg_rdata == 32'h0
  ) else $error("unmapped read not zero");
  // own interrupt only ever follows a request
  a_own_int: assert property (
    intx_pri_assert |-> $past(hp_int_req)) else $error("own interrupt without request");
  a_intx_pass: assert property (
    dn_intx_msg_valid |=> up_intx_msg_valid && up_intx_msg_code == $past(dn_intx_msg_code)
  ) else $error("downstream interrupt message lost");
  // correctable messages pass, nothing appears uncaused
  a_cor_pass: assert property (
    sec_err_valid && sec_err_type == DNP_ERR_COR |=> pri_err_valid
      && pri_err_type == DNP_ERR_COR) else $error("correctable message dropped");
  a_err_cause: assert property (
    pri_err_valid |-> $past(sec_err_valid) && pri_err_type == $past(sec_err_type)
      && pri_err_type != DNP_ERR_NONE) else $error("error message without cause");
  // request answers track the registered enables
  a_mem_req: assert property (
    dn_req_valid && dn_req_space == DNP_SPACE_MEM |=> dn_req_done
      && dn_req_accept == dn_mem_forward_allow) else $error("memory request answer wrong");
  a_io_req: assert property (
    dn_req_valid && dn_req_space == DNP_SPACE_IO |=> dn_req_done
      && dn_req_accept == dn_io_forward_allow) else $error("io request answer wrong");
  a_fwd_master: assert property (
    dn_mem_forward_allow || dn_io_forward_allow |-> dn_initiate_allow
  ) else $error("forwarding without initiator enable");
endmodule // dnp_port_cmd_status_checker

bind dnp_port_cmd_status dnp_port_cmd_status_checker u_chk (
  .clk(clk), .arst_n(arst_n), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack), .hp_int_req(hp_int_req),
  .intx_pri_assert(intx_pri_assert), .dn_intx_msg_valid(dn_intx_msg_valid),
  .dn_intx_msg_code(dn_intx_msg_code), .up_intx_msg_valid(up_intx_msg_valid),
  .up_intx_msg_code(up_intx_msg_code), .sec_err_valid(sec_err_valid),
  .sec_err_type(sec_err_type), .pri_err_valid(pri_err_valid), .pri_err_type(pri_err_type),
  .dn_req_valid(dn_req_valid), .dn_req_space(dn_req_space), .dn_req_done(dn_req_done),
  .dn_req_accept(dn_req_accept), .dn_initiate_allow(dn_initiate_allow),
  .dn_mem_forward_allow(dn_mem_forward_allow), .dn_io_forward_allow(dn_io_forward_allow)
);
`default_nettype wire

// ### verif/dnp_up_port.sv
`timescale 1ns/1ps
`default_nettype none
// upstream port issuing configuration cycles on the internal bus
module dnp_up_port (
  // clock
  input wire logic clk,
  // configuration master side
  output logic cfg_wr_en,
  output logic cfg_rd_en,
  output logic [9:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_ack
);
  // idle bus at time zero
  initial begin
    cfg_wr_en = 1'b0;
    cfg_rd_en = 1'b0;
    cfg_addr = 10'h0;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // one write; released lines turn over so stale values are never trusted
  task automatic wr(input logic [9:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_wr_en <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr_en <= 1'b0;
    cfg_addr <= ~a;
    cfg_be <= ~be;
    cfg_wdata <= ~d;
  endtask
  // one read; answer is looked for after the taking edge, bounded
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cfg_rd_en <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd_en <= 1'b0;
    cfg_addr <= ~a;
    #1;
    while (cfg_rd_ack !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = (cfg_rd_ack === 1'b1) ? cfg_rdata : 32'hXXXX_XXXX;
  endtask
endmodule // dnp_up_port
`default_nettype wire

// ### verif/dnp_port_cmd_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module dnp_port_cmd_status_test;
  import dnp_pkg::*;
  localparam logic [9:0] A = DNP_CMD_STS_DWORD;
  typedef struct {logic [3:0] be; logic [31:0] wd; logic [31:0] rd;} dnp_row_t;
  // byte-lane writes and the dword each leaves behind
  dnp_row_t rows [5] = '{
    '{4'h3, 32'h0000_FFFF, 32'h0010_0547}, '{4'h1, 32'h0000_0000, 32'h0010_0500},
    '{4'h2, 32'h0000_FBFF, 32'h0010_0100}, '{4'hC, 32'hFFFF_FFFF, 32'h0010_0100},
    '{4'h3, 32'h0000_0000, 32'h0010_0000}};
  logic clk, arst_n, cfg_wr_en, cfg_rd_en, cfg_rd_ack, hp_int_req, intx_pri_assert;
  logic [9:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  logic dn_intx_msg_valid, up_intx_msg_valid, sec_err_valid, pri_err_valid, pri_poison_rx;
  logic [2:0] dn_intx_msg_code, up_intx_msg_code, cm;
  dnp_err_t sec_err_type, pri_err_type;
  logic dn_req_valid, dn_req_done, dn_req_accept;
  logic dn_initiate_allow, dn_mem_forward_allow, dn_io_forward_allow;
  dnp_space_t dn_req_space;
  int miscompares = 0, n_compared = 0, cycles = 0;

  dnp_port_cmd_status u_dut (.clk(clk), .arst_n(arst_n), .cfg_wr_en(cfg_wr_en),
    .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rd_ack(cfg_rd_ack), .hp_int_req(hp_int_req),
    .intx_pri_assert(intx_pri_assert), .dn_intx_msg_valid(dn_intx_msg_valid),
    .dn_intx_msg_code(dn_intx_msg_code), .up_intx_msg_valid(up_intx_msg_valid),
    .up_intx_msg_code(up_intx_msg_code), .sec_err_valid(sec_err_valid),
    .sec_err_type(sec_err_type), .pri_err_valid(pri_err_valid), .pri_err_type(pri_err_type),
    .pri_poison_rx(pri_poison_rx), .dn_req_valid(dn_req_valid), .dn_req_space(dn_req_space),
    .dn_req_done(dn_req_done), .dn_req_accept(dn_req_accept),
    .dn_initiate_allow(dn_initiate_allow), .dn_mem_forward_allow(dn_mem_forward_allow),
    .dn_io_forward_allow(dn_io_forward_allow));
  dnp_up_port u_up (.clk(clk), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_ack(cfg_rd_ack));

  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [31:0] exp, input string what);
    u_up.rd(A, d);
    chk(d, exp, what);
  endtask
  // one error message from the secondary side
  task automatic err(input dnp_err_t t, input logic v);
    @(posedge clk);
    sec_err_valid <= 1'b1;
    sec_err_type <= t;
    @(posedge clk);
    sec_err_valid <= 1'b0;
    sec_err_type <= DNP_ERR_NONE;
    #1;
    chk(pri_err_valid, v, "err valid");
    if (v) chk(pri_err_type, t, "err type");
  endtask
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {arst_n, hp_int_req, dn_intx_msg_valid, sec_err_valid, pri_poison_rx, dn_req_valid} = '0;
    dn_intx_msg_code = 3'h0;
    sec_err_type = DNP_ERR_NONE;
    dn_req_space = DNP_SPACE_MEM;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(32'h0010_0000, "reset dword");
    u_up.rd(10'h000, d);
    chk(d, 32'h0, "unmapped read");
    u_up.wr(10'h002, 4'hF, 32'hFFFF_FFFF);
    rdchk(32'h0010_0000, "after unmapped write");
    foreach (rows[i]) begin
      u_up.wr(A, rows[i].be, rows[i].wd);
      rdchk(rows[i].rd, "row dword");
    end
    // severe messages held back while forwarding is off
    err(DNP_ERR_FATAL, 1'b0);
    err(DNP_ERR_NONFATAL, 1'b0);
    err(DNP_ERR_NONE, 1'b0);
    err(DNP_ERR_COR, 1'b1);
    rdchk(32'h0010_0000, "no system error");
    u_up.wr(A, 4'h3, 32'h0000_0100);
    err(DNP_ERR_NONFATAL, 1'b1);
    err(DNP_ERR_FATAL, 1'b1);
    rdchk(32'h4010_0100, "system error sent");
    u_up.wr(A, 4'hC, 32'h0);
    rdchk(32'h4010_0100, "zero write keeps flag");
    @(posedge clk);
    pri_poison_rx <= 1'b1;
    @(posedge clk);
    pri_poison_rx <= 1'b0;
    rdchk(32'hC010_0100, "poison flag");
    u_up.wr(A, 4'h8, 32'h4000_0000);
    rdchk(32'h8010_0100, "clear one flag");
    u_up.wr(A, 4'h8, 32'h8000_0000);
    rdchk(32'h0010_0100, "clear other flag");
    // own interrupt gated, downstream messages not
    @(posedge clk);
    hp_int_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(intx_pri_assert, 1'b1, "own int");
    rdchk(32'h0018_0100, "int status");
    u_up.wr(A, 4'h3, 32'h0000_0500);
    repeat (2) @(posedge clk);
    #1;
    chk(intx_pri_assert, 1'b0, "own int masked");
    @(posedge clk);
    dn_intx_msg_valid <= 1'b1;
    dn_intx_msg_code <= 3'h5;
    @(posedge clk);
    dn_intx_msg_valid <= 1'b0;
    hp_int_req <= 1'b0;
    #1;
    chk({up_intx_msg_valid, up_intx_msg_code}, 4'hD, "intx pass");
    // every enable combination against every request space
    for (int c = 0; c < 8; c++) begin
      cm = 3'(c);
      u_up.wr(A, 4'h3, {29'h0, cm});
      @(posedge clk);
      #1;
      chk({dn_initiate_allow, dn_mem_forward_allow, dn_io_forward_allow},
          {cm[2], cm[2] & cm[1], cm[2] & cm[0]}, "enables");
      for (int s = 0; s < 4; s++) begin
        @(posedge clk);
        dn_req_valid <= 1'b1;
        dn_req_space <= dnp_space_t'(s);
        @(posedge clk);
        dn_req_valid <= 1'b0;
        #1;
        chk({dn_req_done, dn_req_accept}, {1'b1, s == 0 ? cm[2] & cm[1] : s == 1 ?
            cm[2] & cm[0] : s == 2}, "request answer");
      end
    end
    // event and write-one clear in the same cycle: the event wins
    fork
      u_up.wr(A, 4'h8, 32'h8000_0000);
      begin
        @(posedge clk);
        pri_poison_rx <= 1'b1;
        @(posedge clk);
        pri_poison_rx <= 1'b0;
      end
    join
    rdchk(32'h8010_0007, "set beats clear");
    // mid-run reset brings registers, flags and outputs back to defaults
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({dn_initiate_allow, dn_mem_forward_allow, pri_err_type}, 4'h3, "in reset");
    @(posedge clk);
    arst_n <= 1'b1;
    rdchk(32'h0010_0000, "after reset");
    wrap_up();
  end
endmodule // dnp_port_cmd_status_test
`default_nettype wire
